// file: verilog/dram_latency_mode_registers.sv
// Latency and I/O mode registers with dual set-point copies, decoded latencies and precharge placement.
// Assumes commands arrive as one-cycle strobes from controller logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dram_latency_mode_registers
  import dram_latency_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  mrw_valid,
  input  wire logic                  mrr_valid,
  input  wire logic [`MR_ADDR_W-1:0] mr_addr,
  input  wire logic [7:0]            mr_wdata,
  input  wire logic                  write_set_point_select,
  input  wire logic                  operating_set_point_select,
  input  wire logic                  burst_32,
  input  wire logic                  read_ap_done,
  input  wire logic                  write_ap_done,
  input  wire logic [`LAT_W-1:0]     write_recovery_cycles,
  output var  logic [7:0]            mrr_rdata,
  output var  logic                  mrr_rvalid,
  output var  logic [`LAT_W-1:0]     read_latency_code,
  output var  logic [`LAT_W-1:0]     write_latency_code,
  output var  logic [`RTP_W-1:0]     read_to_precharge_cycles,
  output var  logic                  write_latency_reserved,
  output var  logic                  write_leveling_active,
  output var  logic                  command_violation,
  output var  logic                  read_inversion_enable,
  output var  logic                  write_inversion_enable,
  output var  logic [2:0]            pulldown_drive_strength,
  output var  logic                  repair_protection,
  output var  logic                  write_postamble_length,
  output var  logic                  pullup_calibration_point,
  output var  logic                  precharge_start
);
  top_state_type st_q;
  top_state_type st_d;
  lat_if         lif ();

  logic hit_lat;
  logic hit_io;
  logic clear_level;
  logic wr_sel;
  logic op_sel;
  logic [7:0] io_op;

  assign wr_sel   = write_set_point_select;
  assign op_sel   = operating_set_point_select;
  assign hit_lat  = (mr_addr == `MR_ADDR_LATENCY);
  assign hit_io   = (mr_addr == `MR_ADDR_IOCFG);
  assign clear_level = mrw_valid && hit_lat && !mr_wdata[`WLEV_BIT];

  // The decoder and the I/O field outputs see only the operating copy; read data comes from the write-selected copy.
  assign io_op        = st_q.io_cfg[op_sel];
  assign lif.lat_byte = st_q.lat_cfg[op_sel];
  assign lif.rd_inv   = io_op[`RD_INV_BIT];

  latency_decoder u_decoder (
    .lif (lif.decoder)
  );

  precharge_timer u_timer (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .lif                   (lif.consumer),
    .burst_32              (burst_32),
    .read_ap_done          (read_ap_done),
    .write_ap_done         (write_ap_done),
    .write_recovery_cycles (write_recovery_cycles),
    .precharge_start       (precharge_start)
  );

  always_comb begin
    st_d           = st_q;
    st_d.rvalid    = 1'b0;
    st_d.violation = 1'b0;
    st_d.rd_lat    = lif.rd_lat;
    st_d.wr_lat    = lif.wr_lat;
    st_d.rtp       = lif.rtp;
    st_d.wr_lat_rsvd = lif.wr_lat_rsvd;
    if (st_q.level_active) begin
      // During leveling only the clearing write is honoured; anything else is flagged and dropped,
      // so a misbehaving controller cannot corrupt the latency state mid-training.
      if (clear_level) begin
        st_d.lat_cfg[wr_sel] = mr_wdata;
        st_d.level_active    = 1'b0;
      end else if (mrw_valid || mrr_valid) begin
        st_d.violation = 1'b1;
      end
    end else begin
      if (mrw_valid && hit_lat) begin
        st_d.lat_cfg[wr_sel] = mr_wdata;
        st_d.level_active    = mr_wdata[`WLEV_BIT];
      end
      if (mrw_valid && hit_io) begin
        // Repair protection is sticky; only reset clears it.
        st_d.io_cfg[wr_sel] = mr_wdata | (st_q.io_cfg[wr_sel] & 8'h04);
      end
      if (mrr_valid) begin
        st_d.rvalid = 1'b1;
        if (hit_lat) begin
          st_d.rdata = st_q.lat_cfg[wr_sel];
        end else if (hit_io) begin
          st_d.rdata = st_q.io_cfg[wr_sel];
        end else begin
          st_d.rdata = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.lat_cfg     <= {2{`LATENCY_RESET}};
      st_q.io_cfg      <= {2{`IOCFG_RESET}};
      st_q.level_active <= 1'b0;
      st_q.rdata        <= 8'h00;
      st_q.rvalid       <= 1'b0;
      st_q.violation    <= 1'b0;
      st_q.rd_lat       <= `RDLAT_RESET;
      st_q.wr_lat       <= `WRLAT_RESET;
      st_q.rtp          <= `RTP_RESET;
      st_q.wr_lat_rsvd  <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // The I/O fields follow the operating copy; registered here so each output is a flop.
  logic [7:0] io_out_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_out_q <= `IOCFG_RESET;
    end else begin
      io_out_q <= io_op;
    end
  end

  assign mrr_rdata                = st_q.rdata;
  assign mrr_rvalid               = st_q.rvalid;
  assign read_latency_code        = st_q.rd_lat;
  assign write_latency_code       = st_q.wr_lat;
  assign read_to_precharge_cycles = st_q.rtp;
  assign write_latency_reserved   = st_q.wr_lat_rsvd;
  assign write_leveling_active    = st_q.level_active;
  assign command_violation        = st_q.violation;
  assign pullup_calibration_point = io_out_q[`PULLUP_CAL_BIT];
  assign write_postamble_length   = io_out_q[`POSTAMBLE_BIT];
  assign repair_protection        = io_out_q[`REPAIR_BIT];
  assign pulldown_drive_strength  = io_out_q[`PULLDOWN_MSB:`PULLDOWN_LSB];
  assign read_inversion_enable    = io_out_q[`RD_INV_BIT];
  assign write_inversion_enable   = io_out_q[`WR_INV_BIT];

  property p_rdlat_plain;
    @(posedge clk) disable iff (!rst_n)
    (!lif.rd_inv && lif.lat_byte[2:0] == 3'h7) |=> read_latency_code == 6'h24 && read_to_precharge_cycles == 5'h10;
  endproperty
  a_rdlat_plain: assert property (p_rdlat_plain) else $error("read latency code 7 without inversion not 36");

  property p_rdlat_inv;
    @(posedge clk) disable iff (!rst_n)
    (lif.rd_inv && lif.lat_byte[2:0] == 3'h1) |=> read_latency_code == 6'h0C && read_to_precharge_cycles == 5'h08;
  endproperty
  a_rdlat_inv: assert property (p_rdlat_inv) else $error("read latency code 1 with inversion not 12");

  property p_wrlat_set_a;
    @(posedge clk) disable iff (!rst_n)
    (!lif.lat_byte[`WRLAT_SET_BIT] && lif.lat_byte[5:3] == 3'h7) |=> write_latency_code == 6'h12;
  endproperty
  a_wrlat_set_a: assert property (p_wrlat_set_a) else $error("set A code 7 not 18");

  property p_wrlat_set_b;
    @(posedge clk) disable iff (!rst_n)
    (lif.lat_byte[`WRLAT_SET_BIT] && lif.lat_byte[5:3] == 3'h6) |=> write_latency_code == 6'h1E;
  endproperty
  a_wrlat_set_b: assert property (p_wrlat_set_b) else $error("set B code 6 not 30");

  property p_wrlat_reserved;
    @(posedge clk) disable iff (!rst_n)
    (!lif.lat_byte[`WRLAT_SET_BIT] && lif.lat_byte[5:3] == `WRLAT_CODE_RSVD) |=> write_latency_reserved;
  endproperty
  a_wrlat_reserved: assert property (p_wrlat_reserved) else $error("reserved set A code not flagged");

  property p_level_enter;
    @(posedge clk) disable iff (!rst_n)
    (mrw_valid && hit_lat && mr_wdata[`WLEV_BIT] && !write_leveling_active) |=> write_leveling_active;
  endproperty
  a_level_enter: assert property (p_level_enter) else $error("write leveling not entered");

  property p_level_hold;
    @(posedge clk) disable iff (!rst_n)
    (write_leveling_active && !clear_level) |=> write_leveling_active;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("write leveling left without clearing write");

  // A read during leveling must be dropped and flagged, never answered.
  property p_level_drop;
    @(posedge clk) disable iff (!rst_n)
    (write_leveling_active && mrr_valid && !clear_level) |=> command_violation && !mrr_rvalid;
  endproperty
  a_level_drop: assert property (p_level_drop) else $error("read honoured during write leveling");

  property p_write_copy;
    @(posedge clk) disable iff (!rst_n)
    (mrw_valid && hit_lat && !write_leveling_active) |=> st_q.lat_cfg[$past(wr_sel)] == $past(mr_wdata);
  endproperty
  a_write_copy: assert property (p_write_copy) else $error("write landed in wrong set-point copy");

  property p_inactive_copy;
    @(posedge clk) disable iff (!rst_n)
    (mrw_valid && hit_lat && wr_sel != op_sel && !write_leveling_active) ##1 $stable(op_sel)
      |=> $stable(read_latency_code) && $stable(write_latency_code);
  endproperty
  a_inactive_copy: assert property (p_inactive_copy) else $error("inactive copy changed operation");

  property p_read_back;
    @(posedge clk) disable iff (!rst_n)
    (mrr_valid && hit_lat && !write_leveling_active) |=> mrr_rvalid && mrr_rdata == $past(st_q.lat_cfg[wr_sel]);
  endproperty
  a_read_back: assert property (p_read_back) else $error("latency register read back wrong");

  property p_repair_sticky;
    @(posedge clk) disable iff (!rst_n)
    st_q.io_cfg[0][`REPAIR_BIT] |=> st_q.io_cfg[0][`REPAIR_BIT];
  endproperty
  a_repair_sticky: assert property (p_repair_sticky) else $error("repair protection cleared without reset");
endmodule
`default_nettype wire

// file: include/dram_latency_map.svh
// Constants for the latency and I/O mode-register block: addresses, field positions, reset values, counts.
// Assumes it is included once through the package; holds definitions only.
// Function
// - Read latency decode with read inversion off.
// - Read latency decode with read inversion on.
// - Write latency set A decode.
// - Write latency set B decode.
// - Bit 6 picks write latency set.
// - Bit 7 enables write leveling.
// - Write leveling holds until cleared by write.
// - Writes and reads use write set-point copy.
// - Operation uses operating set-point copy only.
// - Burst 32 adds eight clocks to read precharge.
// - Read auto-precharge counts read-to-precharge cycles.
// - Write auto-precharge counts write-recovery cycles.
// - Latency register at 02h, field layout.
// - I/O register at 03h, field layout.
`ifndef DRAM_LATENCY_MAP_SVH
`define DRAM_LATENCY_MAP_SVH
`define MR_ADDR_W       6
`define MR_ADDR_LATENCY 6'h02
`define MR_ADDR_IOCFG   6'h03
`define LATENCY_RESET   8'h00
`define IOCFG_RESET     8'h31
`define RDLAT_MSB       2
`define RDLAT_LSB       0
`define WRLAT_MSB       5
`define WRLAT_LSB       3
`define WRLAT_SET_BIT   6
`define WLEV_BIT        7
`define PULLUP_CAL_BIT  0
`define POSTAMBLE_BIT   1
`define REPAIR_BIT      2
`define PULLDOWN_MSB    5
`define PULLDOWN_LSB    3
`define RD_INV_BIT      6
`define WR_INV_BIT      7
`define LAT_W           6
`define RTP_W           5
`define CNT_W           7
`define RDLAT_RESET     6'h06
`define WRLAT_RESET     6'h04
`define RTP_RESET       5'h08
`define BL32_EXTRA      7'h08
`define WRLAT_CODE_RSVD 3'h3
`endif

// file: include/dram_latency_pkg.sv
// Types shared by the mode-register block and its helpers.
// Assumes the constant header is on the include path.
`default_nettype none
package dram_latency_pkg;
  `include "dram_latency_map.svh"

  typedef struct packed {
    logic [1:0][7:0]      lat_cfg;
    logic [1:0][7:0]      io_cfg;
    logic                 level_active;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 violation;
    logic [`LAT_W-1:0]    rd_lat;
    logic [`LAT_W-1:0]    wr_lat;
    logic [`RTP_W-1:0]    rtp;
    logic                 wr_lat_rsvd;
  } top_state_type;

  typedef struct packed {
    logic [`CNT_W-1:0]    count;
    logic                 start;
  } timer_state_type;
endpackage
`default_nettype wire

// file: include/lat_if.sv
// Carries the operating latency byte to the decoder and the decoded values back.
// Assumes one clock domain; all signals are combinational between modules.
`timescale 1ns/1ps
`default_nettype none
interface lat_if;
  import dram_latency_pkg::*;
  logic [7:0]          lat_byte;
  logic                rd_inv;
  logic [`LAT_W-1:0]   rd_lat;
  logic [`LAT_W-1:0]   wr_lat;
  logic [`RTP_W-1:0]   rtp;
  logic                wr_lat_rsvd;
  modport owner    (output lat_byte, output rd_inv, input rd_lat, input wr_lat, input rtp, input wr_lat_rsvd);
  modport decoder  (input lat_byte, input rd_inv, output rd_lat, output wr_lat, output rtp, output wr_lat_rsvd);
  modport consumer (input rtp);
endinterface
`default_nettype wire

// file: verilog/latency_decoder.sv
// Decodes the operating latency byte into read latency, write latency and read-to-precharge clocks.
// Assumes the owner presents the operating set-point copy and its read inversion bit.
`timescale 1ns/1ps
`default_nettype none
module latency_decoder
  import dram_latency_pkg::*;
(
  lat_if.decoder lif
);
  logic [2:0] rd_code;
  logic [2:0] wr_code;

  assign rd_code = lif.lat_byte[`RDLAT_MSB:`RDLAT_LSB];
  assign wr_code = lif.lat_byte[`WRLAT_MSB:`WRLAT_LSB];

  always_comb begin
    lif.wr_lat_rsvd = 1'b0;
    unique case (rd_code)
      3'h0: begin lif.rd_lat = 6'h06; lif.rtp = 5'h08; end
      3'h1: begin lif.rd_lat = lif.rd_inv ? 6'h0C : 6'h0A; lif.rtp = 5'h08; end
      3'h2: begin lif.rd_lat = lif.rd_inv ? 6'h10 : 6'h0E; lif.rtp = 5'h08; end
      3'h3: begin lif.rd_lat = lif.rd_inv ? 6'h16 : 6'h14; lif.rtp = 5'h08; end
      3'h4: begin lif.rd_lat = lif.rd_inv ? 6'h1C : 6'h18; lif.rtp = 5'h0A; end
      3'h5: begin lif.rd_lat = lif.rd_inv ? 6'h20 : 6'h1C; lif.rtp = 5'h0C; end
      3'h6: begin lif.rd_lat = lif.rd_inv ? 6'h24 : 6'h20; lif.rtp = 5'h0E; end
      3'h7: begin lif.rd_lat = lif.rd_inv ? 6'h28 : 6'h24; lif.rtp = 5'h10; end
    endcase
    if (lif.lat_byte[`WRLAT_SET_BIT]) begin
      unique case (wr_code)
        3'h0: lif.wr_lat = 6'h04;
        3'h1: lif.wr_lat = 6'h08;
        3'h2: lif.wr_lat = 6'h0C;
        3'h3: lif.wr_lat = 6'h12;
        3'h4: lif.wr_lat = 6'h14;
        3'h5: lif.wr_lat = 6'h1A;
        3'h6: lif.wr_lat = 6'h1E;
        3'h7: lif.wr_lat = 6'h22;
      endcase
    end else begin
      unique case (wr_code)
        3'h0: lif.wr_lat = 6'h04;
        3'h1: lif.wr_lat = 6'h08;
        3'h2: lif.wr_lat = 6'h0A;
        3'h3: begin lif.wr_lat = 6'h00; lif.wr_lat_rsvd = 1'b1; end
        3'h4: lif.wr_lat = 6'h0C;
        3'h5: lif.wr_lat = 6'h0E;
        3'h6: lif.wr_lat = 6'h10;
        3'h7: lif.wr_lat = 6'h12;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verilog/precharge_timer.sv
// Places the start of the internal precharge after a read or write burst with auto-precharge.
// Assumes the burst-end strobes are one-cycle pulses from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module precharge_timer
  import dram_latency_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  lat_if.consumer                 lif,
  input  wire logic               burst_32,
  input  wire logic               read_ap_done,
  input  wire logic               write_ap_done,
  input  wire logic [`LAT_W-1:0]  write_recovery_cycles,
  output var  logic               precharge_start
);
  timer_state_type st_q;
  timer_state_type st_d;

  always_comb begin
    st_d = st_q;
    // A burst end that restarts the count also cancels the pulse the old count was about to give.
    st_d.start = (st_q.count == 7'h01) && !read_ap_done && !write_ap_done;
    if (st_q.count != 7'h00) begin
      st_d.count = st_q.count - 7'h01;
    end
    // A new burst end restarts the count; write wins if both arrive together.
    if (write_ap_done) begin
      st_d.count = {1'b0, write_recovery_cycles};
    end else if (read_ap_done) begin
      st_d.count = {2'b00, lif.rtp} + (burst_32 ? `BL32_EXTRA : 7'h00);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign precharge_start = st_q.start;

  property p_read_count;
    @(posedge clk) disable iff (!rst_n)
    (read_ap_done && !write_ap_done && !burst_32 && lif.rtp == 5'h08)
      ##1 (!read_ap_done && !write_ap_done)[*8] |=> precharge_start;
  endproperty
  a_read_count: assert property (p_read_count) else $error("read precharge not placed after 8 clocks");

  property p_bl32_extra;
    @(posedge clk) disable iff (!rst_n)
    (read_ap_done && !write_ap_done && burst_32) |=> st_q.count == {2'b00, $past(lif.rtp)} + 7'h08;
  endproperty
  a_bl32_extra: assert property (p_bl32_extra) else $error("burst 32 did not add 8 clocks");

  property p_write_count;
    @(posedge clk) disable iff (!rst_n)
    write_ap_done |=> st_q.count == {1'b0, $past(write_recovery_cycles)} && !precharge_start;
  endproperty
  a_write_count: assert property (p_write_count) else $error("write recovery count not loaded");
endmodule
`default_nettype wire

// file: tb/controller_model.sv
// Controller-side model that issues single mode register writes and reads.
// Assumes the bench clock and that commands change only at falling edges.
`timescale 1ns/1ps
`default_nettype none
module controller_model
  import dram_latency_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  leveling,
  output var  logic                  mrw_valid,
  output var  logic                  mrr_valid,
  output var  logic [`MR_ADDR_W-1:0] mr_addr,
  output var  logic [7:0]            mr_wdata
);
  logic break_ok = 1'b0;

  initial begin
    mrw_valid = 1'b0;
    mrr_valid = 1'b0;
    mr_addr   = 6'h2A;
    mr_wdata  = 8'h5A;
  end

  // While leveling only the clearing write goes out, unless a test sets break_ok on purpose.
  task automatic issue(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    if (leveling && !(wr && a == `MR_ADDR_LATENCY && !d[`WLEV_BIT]) && !break_ok) begin
      return;
    end
    mrw_valid <= wr;
    mrr_valid <= !wr;
    mr_addr   <= a;
    mr_wdata  <= d;
    @(negedge clk);
    mrw_valid <= 1'b0;
    mrr_valid <= 1'b0;
    // Released lines show the inverse so nothing can lean on a stale value.
    mr_addr   <= ~a;
    mr_wdata  <= ~d;
  endtask
endmodule
`default_nettype wire

// file: tb/dram_latency_mode_registers_test.sv
// Self-checking bench for the latency and I/O mode registers with a controller model.
// Assumes the package and its constant header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dram_latency_mode_registers_test;
  import dram_latency_pkg::*;
  localparam logic [7:0] rdlat_a [8] = '{8'h06, 8'h0A, 8'h0E, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  localparam logic [7:0] rdlat_b [8] = '{8'h06, 8'h0C, 8'h10, 8'h16, 8'h1C, 8'h20, 8'h24, 8'h28};
  localparam logic [7:0] rtp_t [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10};
  localparam logic [7:0] wrlat_a [8] = '{8'h04, 8'h08, 8'h0A, 8'h00, 8'h0C, 8'h0E, 8'h10, 8'h12};
  localparam logic [7:0] wrlat_b [8] = '{8'h04, 8'h08, 8'h0C, 8'h12, 8'h14, 8'h1A, 8'h1E, 8'h22};
  logic clk, rst_n, wsel, opsel, burst_32, read_ap_done, write_ap_done;
  logic [`LAT_W-1:0] write_recovery_cycles;
  logic mrw_valid, mrr_valid, mrr_rvalid, write_latency_reserved, write_leveling_active, command_violation;
  logic [`MR_ADDR_W-1:0] mr_addr;
  logic [7:0] mr_wdata, mrr_rdata;
  logic [`LAT_W-1:0] read_latency_code, write_latency_code;
  logic [`RTP_W-1:0] read_to_precharge_cycles;
  logic read_inversion_enable, write_inversion_enable, repair_protection;
  logic write_postamble_length, pullup_calibration_point, precharge_start;
  logic [2:0] pulldown_drive_strength;
  logic [7:0] lat [2];
  logic [7:0] io [2];
  logic lev;
  int bad_count, checked, cycles;

  controller_model u_controller_model (.clk(clk), .leveling(write_leveling_active), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata));

  dram_latency_mode_registers u_dram_latency_mode_registers (.clk(clk), .rst_n(rst_n), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata), .write_set_point_select(wsel),
    .operating_set_point_select(opsel), .burst_32(burst_32), .read_ap_done(read_ap_done),
    .write_ap_done(write_ap_done), .write_recovery_cycles(write_recovery_cycles), .mrr_rdata(mrr_rdata),
    .mrr_rvalid(mrr_rvalid), .read_latency_code(read_latency_code), .write_latency_code(write_latency_code),
    .read_to_precharge_cycles(read_to_precharge_cycles), .write_latency_reserved(write_latency_reserved),
    .write_leveling_active(write_leveling_active), .command_violation(command_violation),
    .read_inversion_enable(read_inversion_enable), .write_inversion_enable(write_inversion_enable),
    .pulldown_drive_strength(pulldown_drive_strength), .repair_protection(repair_protection),
    .write_postamble_length(write_postamble_length), .pullup_calibration_point(pullup_calibration_point),
    .precharge_start(precharge_start));

  // 40 MHz sits inside the band of the lowest latency setting.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Decoded outputs always follow the operating copy, never the write-selected one.
  task automatic expect_all();
    logic [7:0] l;
    logic [7:0] i;
    l = lat[opsel];
    i = io[opsel];
    check(8'(read_latency_code), i[6] ? rdlat_b[l[2:0]] : rdlat_a[l[2:0]]);
    check(8'(write_latency_code), l[6] ? wrlat_b[l[5:3]] : wrlat_a[l[5:3]]);
    check(8'(read_to_precharge_cycles), rtp_t[l[2:0]]);
    check(8'(write_latency_reserved), 8'(!l[6] && l[5:3] == 3'h3));
    check(8'(write_leveling_active), 8'(lev));
    check({write_inversion_enable, read_inversion_enable, pulldown_drive_strength, repair_protection,
           write_postamble_length, pullup_calibration_point}, i);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a == `MR_ADDR_LATENCY) begin
      lat[wsel] = d;
      lev = d[7];
    end
    // The repair protection bit can only be cleared by reset.
    if (a == `MR_ADDR_IOCFG) begin
      io[wsel] = d | (io[wsel] & 8'h04);
    end
    u_controller_model.issue(1'b1, a, d);
    @(negedge clk);
    expect_all();
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    u_controller_model.issue(1'b0, a, 8'h00);
    check(8'(mrr_rvalid), 8'h01);
    check(mrr_rdata, e);
  endtask

  task automatic pre(input logic rd_kind);
    int n;
    int k;
    n = rd_kind ? rtp_t[lat[opsel][2:0]] + (burst_32 ? 8 : 0) : write_recovery_cycles;
    @(negedge clk);
    read_ap_done = rd_kind;
    write_ap_done = !rd_kind;
    k = 0;
    do begin
      @(negedge clk);
      read_ap_done = 1'b0;
      write_ap_done = 1'b0;
      k++;
    end while (precharge_start !== 1'b1 && k < 100);
    // The first look falls after the taking edge itself, so k counts one edge more than the delay.
    check(8'(k - 1), 8'(n));
    @(negedge clk);
    check(8'(precharge_start), 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    {wsel, opsel, burst_32, read_ap_done, write_ap_done, lev} = 6'h00;
    write_recovery_cycles = 6'h06;
    lat = '{8'h00, 8'h00};
    io = '{8'h31, 8'h31};
    void'($urandom(32'h90CE8881));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    expect_all();
    rd(`MR_ADDR_LATENCY, 8'h00);
    rd(`MR_ADDR_IOCFG, 8'h31);
    rd(6'h05, 8'h00);
    // Every latency code of both sets under both read inversion settings.
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 4; s++) begin
        wr(`MR_ADDR_IOCFG, {1'b0, s[1], 6'h31});
        wr(`MR_ADDR_LATENCY, {1'b0, s[0], c[2:0], c[2:0]});
      end
    end
    wsel = 1'b1;
    wr(`MR_ADDR_LATENCY, 8'h7F);
    rd(`MR_ADDR_LATENCY, 8'h7F);
    opsel = 1'b1;
    repeat (3) @(negedge clk);
    expect_all();
    wr(`MR_ADDR_LATENCY, 8'h87);
    u_controller_model.break_ok = 1'b1;
    u_controller_model.issue(1'b0, `MR_ADDR_LATENCY, 8'h00);
    check(8'(command_violation), 8'h01);
    check(8'(mrr_rvalid), 8'h00);
    u_controller_model.issue(1'b1, `MR_ADDR_IOCFG, 8'hFF);
    check(8'(command_violation), 8'h01);
    u_controller_model.break_ok = 1'b0;
    wr(`MR_ADDR_LATENCY, 8'h07);
    wr(`MR_ADDR_IOCFG, 8'h04);
    wr(`MR_ADDR_IOCFG, 8'h00);
    for (int n = 0; n < 16; n++) begin
      wsel = 1'($urandom);
      opsel = 1'($urandom);
      wr(`MR_ADDR_IOCFG, 8'($urandom));
      wr(`MR_ADDR_LATENCY, 8'($urandom) & 8'h7F);
      rd(`MR_ADDR_LATENCY, lat[wsel]);
      rd(`MR_ADDR_IOCFG, io[wsel]);
      burst_32 = 1'($urandom);
      write_recovery_cycles = 6'($urandom_range(1, 40));
      pre(1'($urandom));
    end
    burst_32 = 1'b1;
    pre(1'b1);
    summarize();
  end
endmodule
`default_nettype wire
